// ### hdl/sscf_consts.svh
`ifndef SSCF_CONSTS_SVH
`define SSCF_CONSTS_SVH

// ==========================================
// Register byte offsets
`define SSCF_OFF_STATUS  8'h00
`define SSCF_OFF_MODE    8'h04
`define SSCF_OFF_CTRL    8'h08
`define SSCF_OFF_RXBUF   8'h0C
`define SSCF_OFF_TXHOLD  8'h10

// ==========================================
// Reset values
`define SSCF_STATUS_RST  8'h84
`define SSCF_MODE_RST    8'h00
`define SSCF_CTRL_RST    8'h00
`define SSCF_DATA_RST    8'h00

// ==========================================
// Status register bit positions
`define SSCF_B_TXEMPTY   7
`define SSCF_B_RXFULL    6
`define SSCF_B_OVERRUN   5
`define SSCF_B_FRAMING   4
`define SSCF_B_PARITY    3
`define SSCF_B_TXEND     2
`define SSCF_B_RXMP      1
`define SSCF_B_TXMP      0

// ==========================================
// Mode register bit positions
`define SSCF_M_SYNC      7
`define SSCF_M_CHAR7     6
`define SSCF_M_PAREN     5
`define SSCF_M_ODD       4
`define SSCF_M_STOP2     3
`define SSCF_M_MPFMT     2

// ==========================================
// Control register bit positions
`define SSCF_C_TXEN      5
`define SSCF_C_RXON      4

`endif

// ### hdl/sscf_pkg.sv
package sscf_pkg;

    // ==========================================
    // Types
    typedef logic [7:0] sscf_byte_t;

    typedef enum logic [1:0] {
        SSCF_RX_NONE    = 2'b00,
        SSCF_RX_OVERRUN = 2'b01,
        SSCF_RX_ERROR   = 2'b10,
        SSCF_RX_GOOD    = 2'b11
    } sscf_rx_res_t;

endpackage : sscf_pkg

// ### hdl/sscf_status.sv
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "sscf_consts.svh"
// Overview of operation
// - Overrun set when char ends, rx full
// - Overrun keeps old buffer, drops new
// - Overrun cleared by reset, standby, read-write0
// - Receiver disable leaves error flags alone
// - Reception stalls while any error flag
// - Synchronous mode: errors also stall transmit
// - Async framing flag when stop bit zero
// - Only first stop bit is checked
// - Error char stored, rx full not set
// - Async parity flag on odd/even mismatch
// - Framing, parity cleared by reset, read-write0
// - Transmit end flag ignores writes
// - Tx end set on last bit, empty
// - Tx end set when transmitter disabled
// - Tx end cleared by empty clear, DMA
// - Received multiprocessor bit captured in async multiprocessor format, read-only
// - Receiver disable keeps received multiprocessor bit
// - Transmit multiprocessor bit appended in async multiprocessor format
// - Transmit multiprocessor bit ignored otherwise
// - Status resets to 84 hex, standby too
// - Writing one does nothing; read first
// - Rx full set on clean reception
module sscf_status (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        standby,
    input  wire logic        rx_done,
    input  wire logic [7:0]  rx_char,
    input  wire logic        rx_parity,
    input  wire logic        rx_stop1,
    input  wire logic        rx_mp_in,
    input  wire logic        tx_load,
    input  wire logic        tx_last_bit,
    input  wire logic        dma_tx_write,
    input  wire logic [7:0]  dma_tx_data,
    input  wire logic        dma_rx_read,
    output logic [7:0]       mode_out,
    output logic             rx_run,
    output logic             tx_run,
    output logic             tx_pending,
    output logic [7:0]       tx_data_out,
    output logic             tx_mp_out,
    output logic [7:0]       rx_data_out,
    output logic             rx_full_out
);

    // ==========================================
    // Registers
    sscf_pkg::sscf_byte_t mode_r;
    sscf_pkg::sscf_byte_t ctrl_r;
    sscf_pkg::sscf_byte_t rxbuf_r;
    sscf_pkg::sscf_byte_t txhold_r;
    logic                 tx_empty_r;
    logic                 rx_full_r;
    logic                 overrun_r;
    logic                 framing_r;
    logic                 parity_r;
    logic                 tx_end_r;
    logic                 rx_mp_r;
    logic                 tx_mp_r;
    logic [4:0]           armed_r;
    logic                 wr_pend_r;
    logic [7:0]           wr_addr_r;
    logic [31:0]          hrdata_r;

    // ==========================================
    // Combinational terms
    logic                 addr_ok;
    logic                 rd_take;
    logic                 status_rd;
    logic                 wr_status;
    logic                 wr_mode;
    logic                 wr_ctrl;
    logic                 wr_txhold;
    logic [7:0]           wdat;
    logic [7:0]           status_val;
    logic [7:0]           rd_mux;
    logic [4:0]           flag_vec;
    logic [4:0]           bit_zero;
    logic [4:0]           sw_clr;
    logic                 async_mode;
    logic                 any_err;
    logic                 rx_on;
    logic                 transmit_enable;
    logic                 te_clear;
    logic                 par_calc;
    logic                 par_bad;
    logic                 frame_bad;
    sscf_pkg::sscf_rx_res_t rx_res;

    assign rx_on           = ctrl_r[`SSCF_C_RXON];
    assign transmit_enable = ctrl_r[`SSCF_C_TXEN];
    assign async_mode      = ~mode_r[`SSCF_M_SYNC];
    assign any_err         = overrun_r | framing_r | parity_r;

    // ==========================================
    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign addr_ok   = hsel & hready & htrans[1];
    assign rd_take   = addr_ok & ~hwrite;
    assign status_rd = rd_take & (haddr[7:0] == `SSCF_OFF_STATUS);

    assign wdat      = hwdata[7:0];
    assign wr_status = wr_pend_r & (wr_addr_r == `SSCF_OFF_STATUS);
    assign wr_mode   = wr_pend_r & (wr_addr_r == `SSCF_OFF_MODE);
    assign wr_ctrl   = wr_pend_r & (wr_addr_r == `SSCF_OFF_CTRL);
    assign wr_txhold = wr_pend_r & (wr_addr_r == `SSCF_OFF_TXHOLD);

    assign status_val = {tx_empty_r, rx_full_r, overrun_r, framing_r,
                         parity_r, tx_end_r, rx_mp_r, tx_mp_r};

    always_comb begin
        unique case (haddr[7:0])
            `SSCF_OFF_STATUS: rd_mux = status_val;
            `SSCF_OFF_MODE:   rd_mux = mode_r;
            `SSCF_OFF_CTRL:   rd_mux = ctrl_r;
            `SSCF_OFF_RXBUF:  rd_mux = rxbuf_r;
            `SSCF_OFF_TXHOLD: rd_mux = txhold_r;
            default:          rd_mux = 8'h00;
        endcase
    end

    // hsize is not decoded: only whole-word transfers are supported
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok & hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata_r <= {24'h00_0000, rd_mux};
        end
    end

    // ==========================================
    // Mode and control registers
    // Clearing the transmitter enable is seen as a write edge, not a level
    assign te_clear = wr_ctrl & transmit_enable & ~wdat[`SSCF_C_TXEN];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= `SSCF_MODE_RST;
            ctrl_r <= `SSCF_CTRL_RST;
        end else if (standby) begin
            mode_r <= `SSCF_MODE_RST;
            ctrl_r <= `SSCF_CTRL_RST;
        end else begin
            if (wr_mode) begin
                mode_r <= wdat;
            end
            if (wr_ctrl) begin
                ctrl_r <= wdat;
            end
        end
    end

    // ==========================================
    // Read-then-clear arming, one per clearable flag
    assign flag_vec = {tx_empty_r, rx_full_r, overrun_r, framing_r, parity_r};
    assign bit_zero = ~{wdat[`SSCF_B_TXEMPTY], wdat[`SSCF_B_RXFULL],
                        wdat[`SSCF_B_OVERRUN], wdat[`SSCF_B_FRAMING],
                        wdat[`SSCF_B_PARITY]};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_arm
            assign sw_clr[gi] = wr_status & bit_zero[gi] & armed_r[gi];

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    armed_r[gi] <= 1'b0;
                end else if (standby || sw_clr[gi] || !flag_vec[gi]) begin
                    armed_r[gi] <= 1'b0;
                end else if (status_rd) begin
                    armed_r[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // ==========================================
    // Receive outcome
    // Parity mismatch check
    always_comb begin
        par_calc = ^rx_char[6:0] ^ rx_parity;
        if (!mode_r[`SSCF_M_CHAR7]) begin
            par_calc = par_calc ^ rx_char[7];
        end
        par_bad = async_mode & mode_r[`SSCF_M_PAREN] & (par_calc != mode_r[`SSCF_M_ODD]);
    end

    assign frame_bad = async_mode & ~rx_stop1;

    always_comb begin
        rx_res = sscf_pkg::SSCF_RX_NONE;
        if (rx_done && rx_on && !any_err) begin
            if (rx_full_r) begin
                rx_res = sscf_pkg::SSCF_RX_OVERRUN;
            end else if (frame_bad || par_bad) begin
                rx_res = sscf_pkg::SSCF_RX_ERROR;
            end else begin
                rx_res = sscf_pkg::SSCF_RX_GOOD;
            end
        end
    end

    // ==========================================
    // Receive buffer and received multiprocessor bit
    // Overrun drops new char
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxbuf_r <= `SSCF_DATA_RST;
        end else if (rx_res == sscf_pkg::SSCF_RX_ERROR || rx_res == sscf_pkg::SSCF_RX_GOOD) begin
            rxbuf_r <= rx_char;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_mp_r <= 1'b0;
        end else if (standby) begin
            rx_mp_r <= 1'b0;
        end else if (async_mode && mode_r[`SSCF_M_MPFMT] &&
                     (rx_res == sscf_pkg::SSCF_RX_ERROR || rx_res == sscf_pkg::SSCF_RX_GOOD)) begin
            rx_mp_r <= rx_mp_in;
        end
    end

    // ==========================================
    // Receive flags; a hardware set beats a software or DMA clear in the same cycle, but standby beats the set
    // Reset and standby values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_full_r <= 1'b0;
            overrun_r <= 1'b0;
            framing_r <= 1'b0;
            parity_r  <= 1'b0;
        end else if (standby) begin
            rx_full_r <= 1'b0;
            overrun_r <= 1'b0;
            framing_r <= 1'b0;
            parity_r  <= 1'b0;
        end else begin
            if (rx_res == sscf_pkg::SSCF_RX_GOOD) begin
                rx_full_r <= 1'b1;
            end else if (sw_clr[3] || dma_rx_read) begin
                rx_full_r <= 1'b0;
            end
            if (rx_res == sscf_pkg::SSCF_RX_OVERRUN) begin
                overrun_r <= 1'b1;
            end else if (sw_clr[2]) begin
                overrun_r <= 1'b0;
            end
            if (rx_res == sscf_pkg::SSCF_RX_ERROR && frame_bad) begin
                framing_r <= 1'b1;
            end else if (sw_clr[1]) begin
                framing_r <= 1'b0;
            end
            if (rx_res == sscf_pkg::SSCF_RX_ERROR && par_bad) begin
                parity_r <= 1'b1;
            end else if (sw_clr[0]) begin
                parity_r <= 1'b0;
            end
        end
    end

    // ==========================================
    // Transmit holding register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txhold_r <= `SSCF_DATA_RST;
        end else if (dma_tx_write) begin
            txhold_r <= dma_tx_data;
        end else if (wr_txhold) begin
            txhold_r <= wdat;
        end
    end

    // ==========================================
    // Transmit flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_empty_r <= 1'b1;
            tx_end_r   <= 1'b1;
        end else if (standby) begin
            tx_empty_r <= 1'b1;
            tx_end_r   <= 1'b1;
        end else begin
            if (tx_load || te_clear) begin
                tx_empty_r <= 1'b1;
            end else if (sw_clr[4] || dma_tx_write) begin
                tx_empty_r <= 1'b0;
            end
            if ((tx_last_bit && tx_empty_r) || te_clear) begin
                tx_end_r <= 1'b1;
            end else if (sw_clr[4] || dma_tx_write) begin
                tx_end_r <= 1'b0;
            end
        end
    end

    // Only the mp bit is writable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_mp_r <= 1'b0;
        end else if (standby) begin
            tx_mp_r <= 1'b0;
        end else if (wr_status) begin
            tx_mp_r <= wdat[`SSCF_B_TXMP];
        end
    end

    // ==========================================
    // Channel-side outputs
    assign mode_out    = mode_r;
    assign rx_run      = rx_on & ~any_err;
    assign tx_run      = transmit_enable & ~(mode_r[`SSCF_M_SYNC] & any_err);
    assign tx_pending  = ~tx_empty_r;
    assign tx_data_out = txhold_r;
    assign tx_mp_out   = tx_mp_r & async_mode & mode_r[`SSCF_M_MPFMT] & transmit_enable;
    assign rx_data_out = rxbuf_r;
    assign rx_full_out = rx_full_r;

endmodule : sscf_status

// ### test/sscf_status_properties.sv
`timescale 1ns/1ps
module sscf_status_checker (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       standby,
    input wire logic       rx_done,
    input wire logic [7:0] rx_char,
    input wire logic       rx_stop1,
    input wire logic       tx_load,
    input wire logic       dma_tx_write,
    input wire logic [7:0] dma_tx_data,
    input wire logic [7:0] mode_out,
    input wire logic       rx_run,
    input wire logic       tx_run,
    input wire logic       tx_pending,
    input wire logic [7:0] tx_data_out,
    input wire logic       tx_mp_out,
    input wire logic [7:0] rx_data_out,
    input wire logic       rx_full_out
);
    logic take;

    // ==========================================
    // Accepted character
    assign take = rx_done && rx_run && !standby;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================
    // Properties
    rx_stall_a: assert property (rx_done && !rx_run |=> $stable(rx_data_out))
        else $error("rx buffer changed while reception stalled");
    overrun_keep_a: assert property (take && rx_full_out |=> $stable(rx_data_out) && !rx_run)
        else $error("overrun did not keep buffer or stall");
    frame_error_a: assert property (take && !rx_full_out && !rx_stop1 && mode_out[7:6] == 2'h0
        |=> !rx_full_out && !rx_run && rx_data_out == $past(rx_char))
        else $error("bad stop bit handled wrongly");
    good_rx_a: assert property (take && !rx_full_out && rx_stop1 && mode_out[6:5] == 2'h0
        |=> rx_full_out && rx_data_out == $past(rx_char))
        else $error("clean character not stored");
    sync_overrun_a: assert property (take && rx_full_out && mode_out[7] |=> !tx_run)
        else $error("transmit not blocked in sync mode");
    dma_load_a: assert property (dma_tx_write && !tx_load && !standby
        |=> tx_pending && tx_data_out == $past(dma_tx_data))
        else $error("dma write not taken");
    mp_gate_a: assert property (tx_mp_out |-> mode_out[2] && !mode_out[7])
        else $error("tx mp bit outside async mp format");
    standby_clear_a: assert property (standby |=> mode_out == 8'h00 && !rx_full_out && !tx_pending && !rx_run)
        else $error("standby did not clear state");
endmodule : sscf_status_checker

bind sscf_status sscf_status_checker i_sscf_status_checker (.*);

// ### test/sscf_station.sv
`timescale 1ns/1ps
module sscf_station (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] c,
    input  wire logic       p,
    input  wire logic       s,
    input  wire logic       m,
    input  wire logic       ld,
    input  wire logic       lb,
    output logic            rx_done,
    output logic [7:0]      rx_char,
    output logic            rx_parity,
    output logic            rx_stop1,
    output logic            rx_mp_in,
    output logic            tx_load,
    output logic            tx_last_bit
);
    initial {rx_done, rx_char, rx_parity, rx_stop1, rx_mp_in, tx_load, tx_last_bit} = '0;

    // Outside a frame the data lines toggle, so a stale value is never trusted
    always @(posedge clk) begin
        rx_done     <= go;
        rx_char     <= go ? c : ~rx_char;
        rx_parity   <= go ? p : ~rx_parity;
        rx_stop1    <= go ? s : ~rx_stop1;
        rx_mp_in    <= go ? m : ~rx_mp_in;
        tx_load     <= ld;
        tx_last_bit <= lb;
    end
endmodule : sscf_station

// ### test/tb_top.sv
`timescale 1ns/1ps
`include "sscf_consts.svh"
module tb_top;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, standby = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rdat;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = 3'h2;
    logic        go = 0, p = 0, s = 1, m = 0, ld = 0, lb = 0, dw = 0, dr = 0;
    logic [7:0]  c = '0, dd = '0, d8, mode_out, tx_data_out, rx_data_out, rx_char;
    logic        hready, hresp, rx_done, rx_parity, rx_stop1, rx_mp_in, tx_load, tx_last_bit;
    logic        rx_run, tx_run, tx_pending, tx_mp_out, rx_full_out, odd, bad, sev, fr;
    int          failures = 0;
    int          n_checks = 0;

    always #5 hclk = ~hclk;

    sscf_status i_sscf_status (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .standby(standby), .rx_done(rx_done), .rx_char(rx_char), .rx_parity(rx_parity),
        .rx_stop1(rx_stop1), .rx_mp_in(rx_mp_in), .tx_load(tx_load), .tx_last_bit(tx_last_bit),
        .dma_tx_write(dw), .dma_tx_data(dd), .dma_rx_read(dr), .mode_out(mode_out), .rx_run(rx_run),
        .tx_run(tx_run), .tx_pending(tx_pending), .tx_data_out(tx_data_out), .tx_mp_out(tx_mp_out),
        .rx_data_out(rx_data_out), .rx_full_out(rx_full_out));

    sscf_station i_sscf_station (.clk(hclk), .go(go), .c(c), .p(p), .s(s), .m(m), .ld(ld), .lb(lb),
        .rx_done(rx_done), .rx_char(rx_char), .rx_parity(rx_parity), .rx_stop1(rx_stop1),
        .rx_mp_in(rx_mp_in), .tx_load(tx_load), .tx_last_bit(tx_last_bit));

    // ==========================================
    // Checking and bus tasks
    task print_verdict;
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t pin got %b exp %b", $time, got, exp);
        end
    endtask : chk1

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdat = hrdata;
    endtask : ahb

    task wr(input logic [7:0] a, input logic [7:0] d);
        ahb(1'b1, a, {24'h00_0000, d});
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        chk(rdat, {24'h00_0000, e});
    endtask : rd

    // Partner registers the request, so allow one extra edge
    task send(input logic [7:0] ch, input logic pb, input logic sb, input logic mb);
        c  <= ch;
        p  <= pb;
        s  <= sb;
        m  <= mb;
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask : send

    task tx(input logic l, input logic b);
        ld <= l;
        lb <= b;
        @(posedge hclk);
        ld <= 1'b0;
        lb <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask : tx

    // Parity bit that makes a character correct; 7-bit frames leave bit 7 out
    function automatic logic par(input logic [7:0] d, input logic o, input logic s7);
        return ^(d & (s7 ? 8'h7F : 8'hFF)) ^ o;
    endfunction : par

    // Status after one reception from an idle, error-free state
    function automatic logic [7:0] rx_stat(input logic pe, input logic fe);
        return {1'b1, ~(pe | fe), 1'b0, fe, pe, 3'b100};
    endfunction : rx_stat

    // ==========================================
    // Scenarios
    initial begin
        void'($urandom(96));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`SSCF_OFF_STATUS, 8'h84);
        wr(`SSCF_OFF_CTRL, 8'h30);
        send(8'h5A, 1'b0, 1'b1, 1'b0);
        rd(`SSCF_OFF_STATUS, 8'hC4);
        send(8'hA5, 1'b0, 1'b1, 1'b0);
        rd(`SSCF_OFF_STATUS, 8'hE4);
        send(8'h11, 1'b0, 1'b1, 1'b0);
        rd(`SSCF_OFF_RXBUF, 8'h5A);
        wr(`SSCF_OFF_CTRL, 8'h20);
        rd(`SSCF_OFF_STATUS, 8'hE4);
        wr(`SSCF_OFF_STATUS, 8'hFE);
        rd(`SSCF_OFF_STATUS, 8'hE4);
        wr(`SSCF_OFF_STATUS, 8'h80);
        rd(`SSCF_OFF_STATUS, 8'h84);
        wr(`SSCF_OFF_CTRL, 8'h30);
        send(8'h3C, 1'b0, 1'b0, 1'b0);
        rd(`SSCF_OFF_STATUS, 8'h94);
        // A clean character while only a framing error stands must be dropped
        send(8'hC3, 1'b0, 1'b1, 1'b0);
        rd(`SSCF_OFF_STATUS, 8'h94);
        rd(`SSCF_OFF_RXBUF, 8'h3C);
        wr(`SSCF_OFF_STATUS, 8'h80);
        rd(`SSCF_OFF_STATUS, 8'h84);
        for (int i = 0; i < 8; i++) begin
            d8  = 8'($urandom);
            odd = 1'($urandom);
            sev = 1'($urandom);
            bad = (i == 0) ? 1'b1 : 1'($urandom);
            fr  = (i == 1) ? 1'b1 : 1'($urandom);
            wr(`SSCF_OFF_MODE, 8'h28 | {1'b0, sev, 1'b0, odd, 4'h0});
            send(d8, par(d8, odd, sev) ^ bad, ~fr, 1'b0);
            rd(`SSCF_OFF_STATUS, rx_stat(bad, fr));
            chk1(rdat[`SSCF_B_FRAMING], fr);
            rd(`SSCF_OFF_RXBUF, d8);
            wr(`SSCF_OFF_STATUS, 8'h80);
        end
        // Synchronous mode: neither a bad parity nor a zero stop bit counts
        wr(`SSCF_OFF_MODE, 8'hA8);
        send(8'h0F, 1'b1, 1'b0, 1'b0);
        rd(`SSCF_OFF_STATUS, 8'hC4);
        wr(`SSCF_OFF_STATUS, 8'h80);
        wr(`SSCF_OFF_MODE, 8'h04);
        send(8'h42, 1'b0, 1'b1, 1'b1);
        // Not read while set yet, so this write must not clear the full flag
        wr(`SSCF_OFF_STATUS, 8'h80);
        rd(`SSCF_OFF_STATUS, 8'hC6);
        dr <= 1'b1;
        @(posedge hclk);
        dr <= 1'b0;
        @(posedge hclk);
        rd(`SSCF_OFF_STATUS, 8'h86);
        wr(`SSCF_OFF_CTRL, 8'h20);
        rd(`SSCF_OFF_STATUS, 8'h86);
        wr(`SSCF_OFF_STATUS, 8'h81);
        @(posedge hclk);
        chk1(tx_mp_out, 1'b1);
        wr(`SSCF_OFF_MODE, 8'h84);
        @(posedge hclk);
        chk1(tx_mp_out, 1'b0);
        wr(`SSCF_OFF_STATUS, 8'h80);
        wr(`SSCF_OFF_MODE, 8'h00);
        dd <= 8'h77;
        dw <= 1'b1;
        @(posedge hclk);
        dw <= 1'b0;
        @(posedge hclk);
        rd(`SSCF_OFF_STATUS, 8'h02);
        rd(`SSCF_OFF_TXHOLD, 8'h77);
        wr(`SSCF_OFF_STATUS, 8'h04);
        rd(`SSCF_OFF_STATUS, 8'h02);
        tx(1'b1, 1'b0);
        rd(`SSCF_OFF_STATUS, 8'h82);
        tx(1'b0, 1'b1);
        rd(`SSCF_OFF_STATUS, 8'h86);
        wr(`SSCF_OFF_STATUS, 8'h00);
        rd(`SSCF_OFF_STATUS, 8'h02);
        wr(`SSCF_OFF_CTRL, 8'h00);
        rd(`SSCF_OFF_STATUS, 8'h86);
        wr(`SSCF_OFF_MODE, 8'h80);
        wr(`SSCF_OFF_CTRL, 8'h30);
        send(8'h01, 1'b0, 1'b1, 1'b0);
        chk1(tx_run, 1'b1);
        send(8'h02, 1'b0, 1'b1, 1'b0);
        chk1(tx_run, 1'b0);
        standby <= 1'b1;
        @(posedge hclk);
        standby <= 1'b0;
        @(posedge hclk);
        rd(`SSCF_OFF_STATUS, 8'h84);
        print_verdict;
    end

    // Whole run takes well under 1000 cycles
    initial begin
        #50000;
        failures++;
        print_verdict;
    end
endmodule : tb_top
